/* bench/serdes_word_assertions.sv */
// serdes_word_assertions: concurrent checks on the word bus and the serial pair
// assumes one pclk domain; serial inputs come from the bench's loop wires
`timescale 1ns/100ps
module serdes_word_assertions
  import serdes_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tx_reference_word_clock,
  input wire logic prbs_test_enable,
  input wire logic device_enable,
  input wire logic rx_recovered_word_clock,
  input wire logic [15:0] rx_word_drv,
  input wire logic rx_low_k_drv,
  input wire logic rx_high_byte_k_flag,
  input wire logic rx_bus_oe,
  input wire logic serial_out_positive,
  input wire logic serial_out_negative,
  input wire logic serial_out_oe,
  input wire logic serial_in_positive,
  input wire logic serial_in_negative
);
  logic [2:0] run_q;
  logic last_q;
  logic [6:0] quiet_q;
  logic [6:0] prbs_q;
  logic [6:0] los_q;
  logic [6:0] sh_q;
  logic [4:0] since_q;
  logic lost;
  assign lost = serial_in_positive == serial_in_negative;
  // prbs runs hold seven ones, so the run check waits for a settled coded stream
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_q <= 3'h0;
      last_q <= 1'b0;
      quiet_q <= 7'h00;
      prbs_q <= 7'h00;
      los_q <= 7'h00;
      sh_q <= 7'h00;
      since_q <= 5'h00;
    end
    else
    begin
      last_q <= serial_out_positive;
      run_q <= (serial_out_positive != last_q) ? 3'h1 : (run_q == 3'h7) ? 3'h7 : run_q + 3'h1;
      quiet_q <= (!serial_out_oe || prbs_test_enable) ? 7'h00 : (quiet_q == 7'h64) ? 7'h64 :
        quiet_q + 7'h01;
      prbs_q <= (!prbs_test_enable || lost) ? 7'h00 : (prbs_q == 7'h7F) ? 7'h7F : prbs_q + 7'h01;
      los_q <= !lost ? 7'h00 : (los_q == 7'h7F) ? 7'h7F : los_q + 7'h01;
      // mirror of the receive window: a comma may legally move the word phase
      sh_q <= {serial_in_positive, sh_q[6:1]};
      since_q <= (sh_q == COMMA_PLUS || sh_q == COMMA_MINUS) ? 5'h00 :
        (since_q == 5'h1F) ? 5'h1F : since_q + 5'h01;
    end
  end
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_word_strobe: assert property (tx_reference_word_clock |-> ##20 tx_reference_word_clock)
    else $error("word strobe period is not twenty cycles");
  a_rx_period: assert property (rx_recovered_word_clock |-> ##20
    (rx_recovered_word_clock || since_q < 5'h16))
    else $error("receive word pulse period is not twenty cycles");
  a_rx_hold: assert property (!rx_recovered_word_clock |-> $stable(rx_word_drv) &&
    $stable(rx_low_k_drv) && $stable(rx_high_byte_k_flag))
    else $error("receive word changed between pulses");
  a_pair_complement: assert property (serial_out_oe |-> serial_out_negative != serial_out_positive)
    else $error("serial pair not complementary");
  a_oe_follows: assert property (serial_out_oe == $past(device_enable))
    else $error("serial enable does not follow device enable");
  a_park_bus: assert property (!device_enable [*3] |-> !rx_bus_oe && !serial_out_oe)
    else $error("outputs still driven in power-down");
  a_bus_wakes: assert property ($rose(device_enable) |-> ##[1:3] rx_bus_oe)
    else $error("receive bus not driven after enable");
  a_run_limit: assert property (quiet_q == 7'h64 |-> run_q <= 3'h5)
    else $error("serial run longer than five bits");
  a_loss_word: assert property (los_q >= 7'h78 && rx_recovered_word_clock |->
    rx_word_drv == LOS_WORD && rx_low_k_drv && rx_high_byte_k_flag)
    else $error("signal loss word not presented");
  a_prbs_word: assert property (prbs_q >= 7'h78 && rx_recovered_word_clock |->
    rx_word_drv == 16'h0000 && !rx_high_byte_k_flag)
    else $error("prbs mode word not cleared");
  c_prbs_pass: cover property (prbs_q >= 7'h78 && rx_recovered_word_clock && rx_low_k_drv);
  c_loss: cover property (los_q >= 7'h78 && rx_recovered_word_clock);
  c_parked: cover property (!rx_bus_oe && rx_recovered_word_clock);
endmodule : serdes_word_assertions

/* bench/tb.sv */
// tb: host and device joined by the word bus, serial pair looped back
// assumes apb on pclk; a released serial pair toggles both lines alike
`timescale 1ns/100ps
module tb
  import serdes_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, sop, son, soe, pre;
  logic fl = 1'b0;
  logic cut = 1'b0;
  logic flip = 1'b0;
  logic sip, sin;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [31:0] rows [15][2] = '{'{32'h0001_5ABC, 32'h0001_5ABC}, '{32'h0000_1234, 32'h0000_1234},
    '{32'h0001_A53C, 32'h0001_A53C}, '{32'h0001_001C, 32'h0001_001C},
    '{32'h0001_FF5C, 32'h0001_FF5C}, '{32'h0001_807C, 32'h0001_807C},
    '{32'h0001_019C, 32'h0001_019C}, '{32'h0001_7EDC, 32'h0001_7EDC},
    '{32'h0001_C3F7, 32'h0001_C3F7}, '{32'h0001_3CFB, 32'h0001_3CFB},
    '{32'h0001_0FFD, 32'h0001_0FFD}, '{32'h0001_F0FE, 32'h0001_F0FE},
    '{32'h0003_F7BC, 32'h0003_F7BC}, '{32'h0002_FEBC, 32'h0002_FEBC},
    '{32'hFFFC_1234, 32'h0000_1234}};
  // a floating pair reads equal on both lines, which the device sees as loss
  assign sip = (soe && !cut) ? sop ^ flip : fl;
  assign sin = (soe && !cut) ? son ^ flip : fl;
  always #50 pclk = ~pclk;
  always @(posedge pclk) fl <= ~fl;
  serdes_word_if u_if();
  serdes_word_device u_serdes_word_device (.pclk(pclk), .presetn(presetn), .bus(u_if),
    .serial_out_positive(sop), .serial_out_negative(son), .serial_out_oe(soe),
    .pre_emph_20pct(pre), .serial_in_positive(sip), .serial_in_negative(sin));
  serdes_word_host u_serdes_word_host (.pclk(pclk), .presetn(presetn), .bus(u_if), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  serdes_word_assertions u_chk (.pclk(pclk), .presetn(presetn),
    .tx_reference_word_clock(u_if.tx_reference_word_clock),
    .prbs_test_enable(u_if.prbs_test_enable), .device_enable(u_if.device_enable),
    .rx_recovered_word_clock(u_if.rx_recovered_word_clock), .rx_word_drv(u_if.rx_word_drv),
    .rx_low_k_drv(u_if.rx_low_k_drv), .rx_high_byte_k_flag(u_if.rx_high_byte_k_flag),
    .rx_bus_oe(u_if.rx_bus_oe), .serial_out_positive(sop), .serial_out_negative(son),
    .serial_out_oe(soe), .serial_in_positive(sip), .serial_in_negative(sin));
  task automatic close_out();
    if (error_cnt == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
      error_cnt++;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask : rd
  // hang guard, well above the few thousand cycles the sequence needs
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 15000)
    begin
      error_cnt++;
      close_out();
    end
  end
  initial
  begin
    logic [31:0] r;
    logic e;
    logic [6:0] s;
    int n;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(32'(u_if.rx_bus_oe), 32'h0);
    rd(REG_CTRL, r);
    chk(r, 32'h0);
    apb(1'b0, 12'h010, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    wr(REG_CTRL, 32'h1);
    for (int i = 0; i < 15; i++)
    begin
      wr(REG_TXWORD, rows[i][0]);
      repeat (200) @(posedge pclk);
      rd(REG_RXWORD, r);
      chk(r, rows[i][1]);
    end
    wr(REG_TXWORD, 32'h0);
    repeat (100) @(posedge pclk);
    wr(REG_TXWORD, 32'h0001_5ABC);
    n = 0;
    while (!(u_if.tx_reference_word_clock === 1'b1 && u_if.tx_word === 16'h5ABC) && n < 100)
    begin
      @(posedge pclk);
      n++;
    end
    s = 7'h00;
    n = 0;
    while (s !== 7'h1F && s !== 7'h60 && n < 100)
    begin
      @(posedge pclk);
      n++;
      s = {s[5:0], sop};
    end
    chk(32'(n >= 41 && n <= 45), 32'h1);
    while (!(u_if.rx_recovered_word_clock === 1'b1 && u_if.rx_word === 16'h5ABC) && n < 200)
    begin
      @(posedge pclk);
      n++;
    end
    chk(32'(n >= 111 && n <= 146), 32'h1);
    wr(REG_CTRL, 32'h5);
    repeat (3) @(posedge pclk);
    chk(32'(pre), 32'h1);
    wr(REG_CTRL, 32'h1);
    repeat (3) @(posedge pclk);
    chk(32'(pre), 32'h0);
    wr(REG_CTRL, 32'h3);
    wr(REG_TXWORD, 32'h0003_1234);
    repeat (300) @(posedge pclk);
    wr(REG_STATUS, 32'hF);
    repeat (100) @(posedge pclk);
    rd(REG_RXWORD, r);
    chk(r, 32'h0001_0000);
    rd(REG_STATUS, r);
    chk(r & 32'h2, 32'h0);
    flip <= 1'b1;
    @(posedge pclk);
    flip <= 1'b0;
    repeat (100) @(posedge pclk);
    rd(REG_STATUS, r);
    chk(r & 32'h2, 32'h2);
    wr(REG_CTRL, 32'h1);
    cut <= 1'b1;
    repeat (200) @(posedge pclk);
    rd(REG_RXWORD, r);
    chk(r, 32'h0003_FFFF);
    rd(REG_STATUS, r);
    chk(r & 32'h4, 32'h4);
    cut <= 1'b0;
    wr(REG_CTRL, 32'h0);
    repeat (5) @(posedge pclk);
    chk(32'({u_if.rx_bus_oe, soe, u_if.rx_word, u_if.rx_low_byte_k_flag}), 32'h0);
    repeat (200) @(posedge pclk);
    rd(REG_RXWORD, r);
    chk(r, 32'h0002_0000);
    close_out();
  end
endmodule : tb

/* rtl/serdes_pkg.sv */
// serdes_pkg: shared constants of the 16-bit serdes word datapath
// assumes one serial bit per pclk, so one word is twenty pclk cycles
package serdes_pkg;
  // word timing, bit counts in pclk cycles (one bit time each), RX_PIPE_WORDS in words
  localparam logic [4:0] LAST_BIT = 5'h13;
  localparam logic [4:0] TX_LOAD_PHASE = 5'h0F;
  localparam logic [4:0] RX_CAPTURE_CNT = 5'h13;
  localparam logic [4:0] COMMA_CNT_SET = 5'h07;
  localparam int RX_PIPE_WORDS = 3;
  // comma as it sits in rsh[19:13], first bit in rsh[13]
  localparam logic [6:0] COMMA_PLUS = 7'h7C;
  localparam logic [6:0] COMMA_MINUS = 7'h03;
  localparam logic [6:0] PRBS_SEED = 7'h7F;
  // 8b/10b tables, negative disparity column, first bit in the msb
  localparam logic [0:31][5:0] ENC_5B6B = {
    6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
    6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
  localparam logic [0:7][3:0] ENC_3B4B = {
    4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
  localparam logic [5:0] K28_6B = 6'h0F;
  localparam logic [5:0] D7_6B = 6'h38;
  localparam logic [3:0] D3_4B = 4'hC;
  localparam logic [3:0] A7_4B = 4'h7;
  localparam logic [4:0] K28_X = 5'h1C;
  localparam logic [7:0] K23_7 = 8'hF7;
  localparam logic [7:0] K27_7 = 8'hFB;
  localparam logic [7:0] K29_7 = 8'hFD;
  localparam logic [7:0] K30_7 = 8'hFE;
  localparam logic [7:0] K_ERR_BYTE = 8'h00;
  localparam logic [15:0] LOS_WORD = 16'hFFFF;
  // host register map
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_TXWORD = 12'h004;
  localparam logic [11:0] REG_RXWORD = 12'h008;
  localparam logic [11:0] REG_STATUS = 12'h00C;
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_PRBS = 1;
  localparam int CTRL_PRE = 2;
  localparam int WORD_KLO = 16;
  localparam int WORD_KHI = 17;
  localparam int ST_WORD = 0;
  localparam int ST_PRBS = 1;
  localparam int ST_LOS = 2;
  localparam int ST_OE = 3;
  typedef enum logic [2:0] {
    SEL_CTRL = 3'h0,
    SEL_TX = 3'h1,
    SEL_RX = 3'h2,
    SEL_STATUS = 3'h3,
    SEL_NONE = 3'h4
  } reg_sel_t;
endpackage : serdes_pkg

/* rtl/serdes_word_device.sv */
// serdes_word_device: 8b/10b word datapath of the serdes end
// assumes one serial bit per pclk and a host word strobe every 20 cycles
// Overview of operation
// - transmit latency fixed, 34 to 38 bits
// - each byte gets its own encoder
// - k flag per byte selects control encoding
// - prbs enable substitutes 2^7-1 pattern
// - prbs mode ignores host word and flags
// - twenty bits per word, bit 0 first
// - pre-emphasis select: 0 low, 1 high
// - two aligned symbols decode into one word
// - receive outputs valid at word clock edge
// - receive latency fixed, 76 to 107 bits
// - lock within 200 ppm of bit clock
// - comma realigns, comma symbol lands low
// - receive k flags mark control bytes
// - only twelve k characters are accepted
// - bad byte reads as k0.0, alone
// - signal loss gives k31.7 on both bytes
// - remote sends commas only in low byte
// - disable parks serial out, bus, low flag
// - host keeps word clock running when disabled
// - prbs checker drops low k flag on error
// - host word captured on word clock edge
// - self-test pass shows on low k flag
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
module serdes_word_device
  import serdes_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  serdes_word_if.device bus,
  output logic serial_out_positive,
  output logic serial_out_negative,
  output logic serial_out_oe,
  output logic pre_emph_20pct,
  input wire logic serial_in_positive,
  input wire logic serial_in_negative
);

  typedef struct packed {
    logic [4:0] tcnt;
    logic [19:0] st1;
    logic [19:0] st2;
    logic [19:0] tsh;
    logic tout;
    logic tout_n;
    logic toe;
    logic pre;
    logic trd;
    logic [6:0] lfsr;
    logic [19:0] rsh;
    logic [4:0] rcnt;
    logic [RX_PIPE_WORDS-1:0][19:0] pipe;
    logic rrd;
    logic [6:0] chk;
    logic perr;
    logic signal_lost_detector;
    logic [15:0] rw;
    logic rkl;
    logic rkh;
    logic rclk;
    logic roe;
  } state_t;

  state_t s_q;
  state_t s_d;

  function automatic logic bal6(input logic [5:0] c);
    return $countones(c) == 3;
  endfunction : bal6

  function automatic logic kval(input logic [7:0] b);
    return b[4:0] == K28_X || b == K23_7 || b == K27_7 || b == K29_7 || b == K30_7;
  endfunction : kval

  // returns {disparity after, ten bits with the first bit in bit 0}
  function automatic logic [10:0] enc8(
    input logic [7:0] b,
    input logic k,
    input logic rd
  );
    logic [5:0] c6;
    logic [3:0] c4;
    logic r1;
    logic a7;
    logic [4:0] x;
    x = b[4:0];
    c6 = (k && x == K28_X) ? K28_6B : ENC_5B6B[x];
    if (rd && (!bal6(c6) || c6 == D7_6B))
      c6 = ~c6;
    r1 = rd ^ !bal6(c6);
    a7 = (b[7:5] == 3'h7) && (k
      || (!r1 && (x == 5'h11 || x == 5'h12 || x == 5'h14))
      || (r1 && (x == 5'h0B || x == 5'h0D || x == 5'h0E)));
    c4 = a7 ? A7_4B : ENC_3B4B[b[7:5]];
    if (r1 && ($countones(c4) != 2 || c4 == D3_4B))
      c4 = ~c4;
    else if (!r1 && k && x == K28_X && $countones(c4) == 2 && c4 != D3_4B)
      c4 = ~c4;
    return {r1 ^ ($countones(c4) != 2), {<<{c6, c4}}};
  endfunction : enc8

  // returns {disparity after, error, k flag, byte}; search re-encodes
  // every candidate so invalid codes never slip through as data
  function automatic logic [10:0] dec8(
    input logic [9:0] s,
    input logic rd
  );
    logic [5:0] c6;
    logic [4:0] x;
    logic [7:0] b;
    logic [10:0] e;
    logic [10:0] r;
    logic hit;
    c6 = {<<{s[5:0]}};
    x = 5'h00;
    r = {rd, 2'b11, K_ERR_BYTE};
    hit = 1'b0;
    for (int i = 0; i < 32; i++)
    begin
      if (c6 == ENC_5B6B[i] || (c6 == ~ENC_5B6B[i] && (!bal6(c6) || c6 == ~D7_6B)))
        x = i[4:0];
    end
    if (c6 == K28_6B || c6 == ~K28_6B)
      x = K28_X;
    for (int n = 0; n < 32; n++)
    begin
      b = {n[2:0], x};
      e = enc8(b, n[3], rd ^ n[4]);
      if (!hit && e[9:0] == s && (!n[3] || kval(b)))
      begin
        hit = 1'b1;
        r = n[4] ? {e[10], 2'b11, K_ERR_BYTE} : {e[10], 1'b0, n[3], b};
      end
    end
    return r;
  endfunction : dec8

  function automatic logic [26:0] prbs20(input logic [6:0] seed);
    logic [6:0] s;
    logic [19:0] bits;
    s = seed;
    bits = 20'h00000;
    for (int i = 0; i < 20; i++)
    begin
      bits[i] = s[6] ^ s[5];
      s = {s[5:0], bits[i]};
    end
    return {s, bits};
  endfunction : prbs20

  logic [10:0] e0;
  logic [10:0] e1;
  logic [10:0] d0;
  logic [10:0] d1;
  logic [26:0] pr;
  logic comma;
  logic cap;
  logic berr;

  // low byte encodes first, high byte continues its disparity
  assign e0 = enc8(bus.tx_word[7:0], bus.tx_low_byte_k_flag, s_q.trd);
  assign e1 = enc8(bus.tx_word[15:8], bus.tx_high_byte_k_flag, e0[10]);
  assign d0 = dec8(s_q.pipe[RX_PIPE_WORDS-1][9:0], s_q.rrd);
  assign d1 = dec8(s_q.pipe[RX_PIPE_WORDS-1][19:10], d0[10]);
  // a cleared generator would lock at zero, so it restarts from the seed
  assign pr = prbs20(s_q.lfsr == 7'h00 ? PRBS_SEED : s_q.lfsr);
  assign comma = s_q.rsh[19:13] == COMMA_PLUS || s_q.rsh[19:13] == COMMA_MINUS;
  assign cap = s_q.rcnt == RX_CAPTURE_CNT;
  assign berr = bus.prbs_test_enable
    && (serial_in_positive != (s_q.chk[6] ^ s_q.chk[5]));

  always_comb
  begin
    s_d = s_q;
    // transmit: capture on the word strobe, load shifter at a fixed phase
    if (bus.tx_reference_word_clock || s_q.tcnt == LAST_BIT)
      s_d.tcnt = 5'h00;
    else
      s_d.tcnt = s_q.tcnt + 5'h01;
    if (bus.tx_reference_word_clock)
    begin
      if (bus.prbs_test_enable)
        {s_d.lfsr, s_d.st1} = pr;
      else
      begin
        s_d.st1 = {e1[9:0], e0[9:0]};
        s_d.trd = e1[10];
      end
      s_d.st2 = s_q.st1;
    end
    // two word stages plus the load phase give 36 bit times
    if (s_q.tcnt == TX_LOAD_PHASE)
    begin
      s_d.tsh = s_q.st2;
      s_d.tout = s_q.st2[0];
    end
    else
    begin
      s_d.tsh = {1'b0, s_q.tsh[19:1]};
      s_d.tout = s_q.tsh[1];
    end
    s_d.tout_n = ~s_d.tout;
    s_d.toe = bus.device_enable;
    s_d.pre = bus.pre_emphasis_select;
    // receive: same pclk as the far end, so rate offset is nil
    s_d.rsh = {serial_in_positive, s_q.rsh[19:1]};
    s_d.chk = {s_q.chk[5:0], serial_in_positive};
    s_d.signal_lost_detector = serial_in_positive == serial_in_negative;
    if (comma)
      s_d.rcnt = COMMA_CNT_SET;
    else if (cap)
      s_d.rcnt = 5'h00;
    else
      s_d.rcnt = s_q.rcnt + 5'h01;
    s_d.perr = cap ? berr : (s_q.perr | berr);
    s_d.rclk = cap;
    s_d.roe = bus.device_enable;
    if (cap)
    begin
      // word pipe sets the fixed 80 bit receive latency
      s_d.pipe = {s_q.pipe[RX_PIPE_WORDS-2:0], s_q.rsh};
      s_d.rrd = d1[10];
      if (s_q.signal_lost_detector)
      begin
        s_d.rw = LOS_WORD;
        s_d.rkl = 1'b1;
        s_d.rkh = 1'b1;
      end
      else if (bus.prbs_test_enable)
      begin
        s_d.rw = 16'h0000;
        s_d.rkl = !s_q.perr;
        s_d.rkh = 1'b0;
      end
      else
      begin
        s_d.rw = {d1[7:0], d0[7:0]};
        s_d.rkl = d0[8];
        s_d.rkh = d1[8];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign serial_out_positive = s_q.tout;
  assign serial_out_negative = s_q.tout_n;
  assign serial_out_oe = s_q.toe;
  assign pre_emph_20pct = s_q.pre;
  assign bus.rx_recovered_word_clock = s_q.rclk;
  assign bus.rx_word_drv = s_q.rw;
  assign bus.rx_low_k_drv = s_q.rkl;
  assign bus.rx_high_byte_k_flag = s_q.rkh;
  assign bus.rx_bus_oe = s_q.roe;

endmodule : serdes_word_device

/* rtl/serdes_word_host.sv */
// serdes_word_host: host framing end, apb registers to the word bus
// assumes an apb master on pclk; the word strobe runs even when disabled
`timescale 1ns/100ps
module serdes_word_host
  import serdes_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  serdes_word_if.host bus,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  typedef struct packed {
    logic [4:0] div;
    logic wclk;
    logic en;
    logic prbs;
    logic pre;
    logic [15:0] txw;
    logic tkl;
    logic tkh;
    logic [15:0] rxw;
    logic rkl;
    logic rkh;
    logic [2:0] sticky;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_t;

  state_t s_q;
  state_t s_d;

  function automatic reg_sel_t sel_of(input logic [11:0] a);
    if (a == REG_CTRL)
      return SEL_CTRL;
    else if (a == REG_TXWORD)
      return SEL_TX;
    else if (a == REG_RXWORD)
      return SEL_RX;
    else if (a == REG_STATUS)
      return SEL_STATUS;
    else
      return SEL_NONE;
  endfunction : sel_of

  reg_sel_t sel;
  logic acc;
  logic [2:0] ev;
  logic [2:0] clr;

  assign sel = sel_of(paddr);
  assign acc = psel && penable;
  assign ev[ST_WORD] = bus.rx_recovered_word_clock;
  assign ev[ST_PRBS] = bus.rx_recovered_word_clock && s_q.prbs && !bus.rx_low_byte_k_flag;
  assign ev[ST_LOS] = bus.rx_recovered_word_clock && bus.rx_low_byte_k_flag
    && bus.rx_high_byte_k_flag && bus.rx_word == LOS_WORD;
  assign clr = (acc && s_q.pready && pwrite && sel == SEL_STATUS) ? pwdata[2:0] : 3'h0;

  always_comb
  begin
    s_d = s_q;
    // free-running divider: the word clock keeps going in power-down
    s_d.div = (s_q.div == LAST_BIT) ? 5'h00 : s_q.div + 5'h01;
    s_d.wclk = s_q.div == LAST_BIT;
    if (bus.rx_recovered_word_clock)
    begin
      s_d.rxw = bus.rx_word;
      s_d.rkl = bus.rx_low_byte_k_flag;
      s_d.rkh = bus.rx_high_byte_k_flag;
    end
    // an event in the clearing cycle stays set
    s_d.sticky = (s_q.sticky & ~clr) | ev;
    // one wait state: answer registered, write lands with pready
    s_d.pready = acc && !s_q.pready;
    s_d.pslverr = s_d.pready && sel == SEL_NONE;
    if (s_d.pready)
    begin
      s_d.prdata = 32'h00000000;
      if (sel == SEL_CTRL)
        s_d.prdata[2:0] = {s_q.pre, s_q.prbs, s_q.en};
      else if (sel == SEL_TX)
        s_d.prdata[17:0] = {s_q.tkh, s_q.tkl, s_q.txw};
      else if (sel == SEL_RX)
        s_d.prdata[17:0] = {s_q.rkh, s_q.rkl, s_q.rxw};
      else if (sel == SEL_STATUS)
        s_d.prdata[3:0] = {bus.rx_bus_oe, s_q.sticky};
    end
    if (acc && s_q.pready && pwrite)
    begin
      if (sel == SEL_CTRL)
      begin
        s_d.en = pwdata[CTRL_ENABLE];
        s_d.prbs = pwdata[CTRL_PRBS];
        s_d.pre = pwdata[CTRL_PRE];
      end
      else if (sel == SEL_TX)
      begin
        s_d.txw = pwdata[15:0];
        s_d.tkl = pwdata[WORD_KLO];
        s_d.tkh = pwdata[WORD_KHI];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // word and flags held steady across each strobe
  assign bus.tx_reference_word_clock = s_q.wclk;
  assign bus.tx_word = s_q.txw;
  assign bus.tx_low_byte_k_flag = s_q.tkl;
  assign bus.tx_high_byte_k_flag = s_q.tkh;
  assign bus.prbs_test_enable = s_q.prbs;
  assign bus.device_enable = s_q.en;
  assign bus.pre_emphasis_select = s_q.pre;
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;

endmodule : serdes_word_host

/* rtl/serdes_word_if.sv */
// serdes_word_if: parallel word bus between host framing logic and serdes
// assumes both ends run on the same pclk; parked bus lines read as zero
`timescale 1ns/100ps
interface serdes_word_if;
  logic tx_reference_word_clock;
  logic [15:0] tx_word;
  logic tx_low_byte_k_flag;
  logic tx_high_byte_k_flag;
  logic prbs_test_enable;
  logic device_enable;
  logic pre_emphasis_select;
  logic rx_recovered_word_clock;
  logic [15:0] rx_word_drv;
  logic rx_low_k_drv;
  logic rx_high_byte_k_flag;
  logic rx_bus_oe;
  logic [15:0] rx_word;
  logic rx_low_byte_k_flag;

  // undriven bus lines settle low
  assign rx_word = rx_bus_oe ? rx_word_drv : 16'h0000;
  assign rx_low_byte_k_flag = rx_bus_oe ? rx_low_k_drv : 1'b0;

  modport device (
    input tx_reference_word_clock, tx_word, tx_low_byte_k_flag,
    input tx_high_byte_k_flag, prbs_test_enable, device_enable,
    input pre_emphasis_select,
    output rx_recovered_word_clock, rx_word_drv, rx_low_k_drv,
    output rx_high_byte_k_flag, rx_bus_oe
  );
  modport host (
    output tx_reference_word_clock, tx_word, tx_low_byte_k_flag,
    output tx_high_byte_k_flag, prbs_test_enable, device_enable,
    output pre_emphasis_select,
    input rx_recovered_word_clock, rx_word, rx_low_byte_k_flag,
    input rx_high_byte_k_flag, rx_bus_oe
  );
endinterface : serdes_word_if
